// ===== logic/vcc_pkg.sv
package vcc_pkg;
	// ************************************************************
	// code to millivolt conversion
	// ************************************************************
	localparam int unsigned        CODE_W       = 8;
	localparam int unsigned        MV_W         = 11;
	localparam logic [7:0]         CODE_OFF     = 8'h00;
	localparam logic [10:0]        MV_AT_ZERO   = 11'h0f5;
	localparam logic [10:0]        MV_PER_CODE  = 11'h005;

	// ************************************************************
	// adc multiplexer sources
	// ************************************************************
	localparam logic [2:0]         SRC_SET_A    = 3'h0;
	localparam logic [2:0]         SRC_SET_B    = 3'h1;
	localparam logic [2:0]         SRC_SET_C    = 3'h2;
	localparam logic [2:0]         SRC_CURRENT_MONITOR_INPUT     = 3'h3;
	localparam logic [2:0]         SRC_THERM    = 3'h4;

	// ************************************************************
	// slew timing, one code step of 5 mV per interval
	// ************************************************************
	localparam int unsigned        CLK_MHZ      = 250;
	localparam int unsigned        FAST_STEP_NS = 500;
	localparam int unsigned        SLOW_STEP_NS = 2000;
	localparam int unsigned        FAST_STEP_CYC = (FAST_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned        SLOW_STEP_CYC = (SLOW_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned        CNT_W        = 12;

	// ************************************************************
	// sequencer states, gray along off, scan, run
	// ************************************************************
	typedef enum logic [1:0] {
		ST_WAIT_POR = 2'h0,
		ST_SCAN     = 2'h1,
		ST_RUN      = 2'h3,
		ST_FAULT    = 2'h2
	} vcc_state_t;
endpackage

// ===== logic/vcc_voltage_code_control.sv
`timescale 1ns/1ps
module vcc_voltage_code_control #(
	parameter int unsigned FAST_CYC = vcc_pkg::FAST_STEP_CYC,
	parameter int unsigned SLOW_CYC = vcc_pkg::SLOW_STEP_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	input  wire logic        supply_a_good_in,
	input  wire logic        supply_b_good_in,
	input  wire logic        protect_fault_in,
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic        cmd_fast_in,
	output logic             cmd_ready_out,
	output logic             adc_start_out,
	output logic [2:0]       adc_sel_out,
	input  wire logic        adc_done_in,
	input  wire logic [7:0]  adc_data_in,
	output logic [7:0]       setting_a_out,
	output logic [7:0]       setting_b_out,
	output logic [7:0]       setting_c_out,
	output logic [7:0]       current_monitor_input_code_out,
	output logic [7:0]       thermal_code_out,
	output logic             adc_result_valid_out,
	output logic             req_valid_out,
	output logic [7:0]       req_code_out,
	output logic             req_fast_out,
	output logic [7:0]       setpoint_code_out,
	output logic [10:0]      setpoint_mv_out,
	output logic             output_enable_out,
	output logic             phase_enable_out,
	output logic             por_release_out,
	output logic             slewing_out
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		vcc_pkg::vcc_state_t st;
		logic [1:0]          sync_a;
		logic [1:0]          sync_b;
		logic [1:0]          sync_f;
		logic [2:0]          sel;
		logic                busy;
		logic                start;
		logic [7:0]          set_a;
		logic [7:0]          set_b;
		logic [7:0]          set_c;
		logic [7:0]          current_monitor_input;
		logic [7:0]          therm;
		logic                res_valid;
		logic                req_valid;
		logic [7:0]          req_code;
		logic                fast;
		logic [7:0]          target;
		logic [7:0]          cur;
		logic [10:0]         mv;
		logic                off;
		logic [11:0]         cnt;
	} vcc_regs_t;

	vcc_regs_t r;
	vcc_regs_t next_r;
	logic      supplies_ok;
	logic      fault;
	logic [11:0] step_lim;

	assign supplies_ok = r.sync_a[1] & r.sync_b[1];
	assign fault       = r.sync_f[1];
	assign step_lim    = r.fast ? 12'(FAST_CYC - 1) : 12'(SLOW_CYC - 1);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_r           = r;
		next_r.sync_a    = {r.sync_a[0], supply_a_good_in};
		next_r.sync_b    = {r.sync_b[0], supply_b_good_in};
		next_r.sync_f    = {r.sync_f[0], protect_fault_in};
		next_r.start     = 1'b0;
		next_r.res_valid = 1'b0;
		next_r.req_valid = 1'b0;

		// adc scheduling: one conversion at a time, result stored by source
		if (r.st == vcc_pkg::ST_SCAN || r.st == vcc_pkg::ST_RUN) begin
			if (!r.busy) begin
				next_r.busy  = 1'b1;
				next_r.start = 1'b1;
			end else if (adc_done_in && !r.start) begin
				next_r.busy      = 1'b0;
				next_r.res_valid = 1'b1;
				if (r.sel == vcc_pkg::SRC_SET_A) begin
					next_r.set_a = adc_data_in;
				end else if (r.sel == vcc_pkg::SRC_SET_B) begin
					next_r.set_b = adc_data_in;
				end else if (r.sel == vcc_pkg::SRC_SET_C) begin
					next_r.set_c = adc_data_in;
				end else if (r.sel == vcc_pkg::SRC_CURRENT_MONITOR_INPUT) begin
					next_r.current_monitor_input = adc_data_in;
				end else begin
					next_r.therm = adc_data_in;
				end
				// settings are sampled once at start-up; run mode only tracks monitors
				if (r.sel == vcc_pkg::SRC_THERM) begin
					next_r.sel = (r.st == vcc_pkg::ST_RUN) ? vcc_pkg::SRC_CURRENT_MONITOR_INPUT
						: vcc_pkg::SRC_SET_A;
				end else begin
					next_r.sel = r.sel + 3'h1;
				end
			end
		end

		case (r.st)
			vcc_pkg::ST_WAIT_POR: begin
				next_r.sel = vcc_pkg::SRC_SET_A;
				next_r.busy = 1'b0;
				if (supplies_ok) begin
					next_r.st = vcc_pkg::ST_SCAN;
				end
			end
			vcc_pkg::ST_SCAN: begin
				if (adc_done_in && r.busy && !r.start && r.sel == vcc_pkg::SRC_SET_C) begin
					next_r.st = vcc_pkg::ST_RUN;
				end
			end
			vcc_pkg::ST_RUN: begin
				if (fault) begin
					next_r.st = vcc_pkg::ST_FAULT;
				end else if (cmd_valid_in) begin
					next_r.req_valid = 1'b1;
					next_r.req_code  = cmd_code_in;
					next_r.fast      = cmd_fast_in;
					next_r.cnt       = 12'h0000;
					if (cmd_code_in == vcc_pkg::CODE_OFF) begin
						next_r.off    = 1'b1;
						next_r.target = vcc_pkg::CODE_OFF;
						next_r.cur    = vcc_pkg::CODE_OFF;
					end else begin
						next_r.off    = 1'b0;
						next_r.target = cmd_code_in;
					end
				end else if (r.cur != r.target) begin
					if (r.cnt >= step_lim) begin
						next_r.cnt = 12'h0000;
						next_r.cur = (r.cur < r.target) ? r.cur + 8'h01
							: r.cur - 8'h01;
					end else begin
						next_r.cnt = r.cnt + 12'h001;
					end
				end
			end
			default: begin
				// latched until the supplies drop; output held off
				next_r.off    = 1'b1;
				next_r.cur    = vcc_pkg::CODE_OFF;
				next_r.target = vcc_pkg::CODE_OFF;
			end
		endcase

		if (!supplies_ok) begin
			next_r.st     = vcc_pkg::ST_WAIT_POR;
			next_r.off    = 1'b1;
			next_r.cur    = vcc_pkg::CODE_OFF;
			next_r.target = vcc_pkg::CODE_OFF;
		end

		// zero code carries no voltage, so the millivolt word reads zero
		if (next_r.cur == vcc_pkg::CODE_OFF) begin
			next_r.mv = 11'h000;
		end else begin
			next_r.mv = vcc_pkg::MV_AT_ZERO + vcc_pkg::MV_PER_CODE * {3'h0, next_r.cur};
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			r     <= '0;
			r.off <= 1'b1;
		end else if (clk_en_in) begin
			r <= next_r;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign cmd_ready_out        = (r.st == vcc_pkg::ST_RUN) & ~fault;
	assign adc_start_out        = r.start;
	assign adc_sel_out          = r.sel;
	assign setting_a_out        = r.set_a;
	assign setting_b_out        = r.set_b;
	assign setting_c_out        = r.set_c;
	assign current_monitor_input_code_out        = r.current_monitor_input;
	assign thermal_code_out     = r.therm;
	assign adc_result_valid_out = r.res_valid;
	assign req_valid_out        = r.req_valid;
	assign req_code_out         = r.req_code;
	assign req_fast_out         = r.fast;
	assign setpoint_code_out    = r.cur;
	assign setpoint_mv_out      = r.mv;
	assign output_enable_out    = ~r.off & (r.st == vcc_pkg::ST_RUN);
	assign phase_enable_out     = (r.st == vcc_pkg::ST_RUN) & ~r.off;
	assign por_release_out      = (r.st != vcc_pkg::ST_WAIT_POR);
	assign slewing_out          = (r.cur != r.target);
endmodule

// ===== verification/vcc_asserts.sv
`timescale 1ns/1ps
module vcc_asserts (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        supply_a_good_in,
	input wire logic        supply_b_good_in,
	input wire logic        protect_fault_in,
	input wire logic        cmd_valid_in,
	input wire logic [7:0]  cmd_code_in,
	input wire logic        cmd_ready_out,
	input wire logic        adc_start_out,
	input wire logic [2:0]  adc_sel_out,
	input wire logic        adc_done_in,
	input wire logic [7:0]  adc_data_in,
	input wire logic [7:0]  setting_a_out,
	input wire logic        adc_result_valid_out,
	input wire logic        req_valid_out,
	input wire logic [7:0]  req_code_out,
	input wire logic [7:0]  setpoint_code_out,
	input wire logic [10:0] setpoint_mv_out,
	input wire logic        output_enable_out,
	input wire logic        phase_enable_out,
	input wire logic        por_release_out
);
	// start wins over done: done in the start cycle is not a result
	logic busy;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) busy <= 1'b0;
		else if (adc_start_out) busy <= 1'b1;
		else if (adc_done_in) busy <= 1'b0;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_req_forward: assert property (cmd_valid_in && cmd_ready_out |=> req_valid_out &&
		req_code_out == $past(cmd_code_in)) else $error("request not forwarded");
	a_code_to_mv: assert property (setpoint_code_out != 8'h00 |-> setpoint_mv_out ==
		vcc_pkg::MV_AT_ZERO + vcc_pkg::MV_PER_CODE * {3'h0, setpoint_code_out})
		else $error("setpoint millivolts wrong");
	a_zero_is_off: assert property (setpoint_code_out == 8'h00 |-> setpoint_mv_out == 11'h000)
		else $error("code zero not off");
	a_supply_loss: assert property (!supply_a_good_in || !supply_b_good_in |-> ##[1:4]
		!por_release_out) else $error("release held without supplies");
	a_fault_stops: assert property (protect_fault_in |-> ##[1:4] !phase_enable_out &&
		!output_enable_out) else $error("phase enable held after fault");
	a_slew_unit: assert property ($changed(setpoint_code_out) && setpoint_code_out != 8'h00 |->
		setpoint_code_out == $past(setpoint_code_out) + 8'h01 ||
		setpoint_code_out + 8'h01 == $past(setpoint_code_out)) else $error("step not one code");
	a_sel_range: assert property (adc_start_out |-> adc_sel_out <= vcc_pkg::SRC_THERM ##1
		$stable(adc_sel_out)) else $error("bad adc source");
	a_store_setting: assert property (busy && adc_done_in && por_release_out &&
		adc_sel_out == vcc_pkg::SRC_SET_A |=> setting_a_out == $past(adc_data_in) &&
		adc_result_valid_out) else $error("setting not stored");
endmodule
bind vcc_voltage_code_control vcc_asserts chk_u (.*);

// ===== verification/vcc_adc_model.sv
`timescale 1ns/1ps
module vcc_adc_model (
	input wire logic        clk_in,
	input wire logic        clk_en_in,
	input wire logic [7:0]  base_in,
	input wire logic        adc_start_in,
	input wire logic [2:0]  adc_sel_in,
	output logic            adc_done_out,
	output logic [7:0]      adc_data_out
);
	logic [1:0] wait_cnt = 2'h0;
	logic       pend = 1'b0;
	logic       slow = 1'b0;
	initial adc_done_out = 1'b0;
	initial adc_data_out = 8'h00;
	// alternates a prompt and a slow answer; idle data toggles, never holds
	// frozen with the block, so no answer is lost while the enable is low
	always @(posedge clk_in) if (clk_en_in) begin
		adc_done_out <= 1'b0;
		adc_data_out <= ~adc_data_out;
		if (adc_start_in) begin
			pend <= 1'b1;
			wait_cnt <= slow ? 2'h3 : 2'h0;
			slow <= !slow;
		end else if (pend && wait_cnt == 2'h0) begin
			pend <= 1'b0;
			adc_done_out <= 1'b1;
			adc_data_out <= base_in + {5'h00, adc_sel_in};
		end else if (pend) wait_cnt <= wait_cnt - 2'h1;
	end
endmodule

// ===== verification/vcc_voltage_code_control_tb.sv
`timescale 1ns/1ps
module vcc_voltage_code_control_tb;
	logic        clk_in, rst_n_in, clk_en_in, supply_a_good_in, supply_b_good_in;
	logic        protect_fault_in, cmd_valid_in, cmd_fast_in, adc_done_in, adc_start_out;
	logic [7:0]  cmd_code_in, adc_data_in, setting_a_out, setting_b_out, setting_c_out;
	logic [7:0]  current_monitor_input_code_out, thermal_code_out, req_code_out, setpoint_code_out;
	logic        cmd_ready_out, adc_result_valid_out, req_valid_out, req_fast_out;
	logic        output_enable_out, phase_enable_out, por_release_out, slewing_out;
	logic [10:0] setpoint_mv_out;
	logic [2:0]  adc_sel_out;
	logic [8:0]  exp_q[$];
	logic [7:0]  rnd = 8'h1b;
	logic [7:0]  adc_base = 8'h50;
	int          error_cnt = 0, compares = 0, i, t_fast, t_slow;
	vcc_voltage_code_control #(.FAST_CYC(2), .SLOW_CYC(4)) dut_u (.*);
	vcc_adc_model adc_u (.clk_in(clk_in), .clk_en_in(clk_en_in), .base_in(adc_base),
		.adc_start_in(adc_start_out), .adc_sel_in(adc_sel_out),
		.adc_done_out(adc_done_in), .adc_data_out(adc_data_in));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] expv);
		compares++;
		if (seen !== expv) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, expv, seen);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic expire(input int n);
		if (n >= 1000) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic wait_ready();
		for (i = 0; i < 1000 && cmd_ready_out !== 1'b1; i++) @(negedge clk_in);
		expire(i);
	endtask
	// only a command seen while ready is expected to come out
	task automatic send(input logic [7:0] code, input logic fast);
		@(negedge clk_in);
		cmd_valid_in = 1'b1;
		cmd_code_in = code;
		cmd_fast_in = fast;
		if (cmd_ready_out === 1'b1) exp_q.push_back({code, fast});
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
	endtask
	task automatic ramp(input logic [7:0] code, input logic fast, output int n);
		send(code, fast);
		for (n = 0; n < 1000 && setpoint_code_out !== code; n++) @(negedge clk_in);
		expire(n);
		chk("setpoint_mv", setpoint_mv_out, 11'h0f5 + 11'h005 * {3'h0, code});
		chk("output_on", {10'h000, output_enable_out}, 11'h001);
		chk("phase_on", {10'h000, phase_enable_out}, 11'h001);
		chk("slew_done", {10'h000, slewing_out}, 11'h000);
	endtask
	always @(negedge clk_in) if (req_valid_out === 1'b1) begin
		if (exp_q.size() == 0) chk("unexpected_req", 11'h001, 11'h000);
		else chk("req", {2'h0, req_code_out, req_fast_out}, {2'h0, exp_q.pop_front()});
	end
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		{rst_n_in, supply_a_good_in, supply_b_good_in, protect_fault_in} = 4'h0;
		{cmd_valid_in, cmd_fast_in, cmd_code_in} = 10'h000;
		clk_en_in = 1'b1;
		repeat (6) @(negedge clk_in);
		rst_n_in = 1'b1;
		supply_a_good_in = 1'b1;
		repeat (6) @(negedge clk_in);
		chk("por_one_supply", {10'h000, por_release_out}, 11'h000);
		supply_b_good_in = 1'b1;
		wait_ready();
		chk("setting_a", {3'h0, setting_a_out}, 11'h050);
		chk("setting_b", {3'h0, setting_b_out}, 11'h051);
		chk("setting_c", {3'h0, setting_c_out}, 11'h052);
		repeat (20) @(negedge clk_in);
		chk("current_monitor_input", {3'h0, current_monitor_input_code_out}, 11'h053);
		chk("thermal", {3'h0, thermal_code_out}, 11'h054);
		ramp(8'h01, 1'b1, t_fast);
		ramp(8'h49, 1'b0, t_slow);
		// eight codes at two cycles each, then eight at four each
		ramp(8'h41, 1'b1, t_fast);
		chk("fast_time", 11'(t_fast), 11'h010);
		ramp(8'h49, 1'b0, t_slow);
		chk("slow_time", 11'(t_slow), 11'h020);
		chk("slow_longer", {10'h000, t_slow > t_fast}, 11'h001);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			ramp(8'h01 | {1'b0, rnd[6:0]}, rnd[7], t_fast);
		end
		send(8'h60, 1'b1);
		ramp(8'h30, 1'b1, t_fast);
		send(8'h00, 1'b0);
		chk("off_mv", setpoint_mv_out, 11'h000);
		chk("off_enable", {10'h000, output_enable_out}, 11'h000);
		ramp(8'h20, 1'b1, t_fast);
		// freeze mid-slew once the request pulse has gone
		send(8'h28, 1'b0);
		@(negedge clk_in);
		clk_en_in = 1'b0;
		repeat (8) @(negedge clk_in);
		chk("frozen_code", {3'h0, setpoint_code_out}, 11'h020);
		chk("frozen_slew", {10'h000, slewing_out}, 11'h001);
		clk_en_in = 1'b1;
		ramp(8'h28, 1'b0, t_slow);
		chk("resume_time", 11'(t_slow), 11'h020);
		protect_fault_in = 1'b1;
		repeat (4) @(negedge clk_in);
		chk("fault_ready", {10'h000, cmd_ready_out}, 11'h000);
		chk("fault_enable", {10'h000, output_enable_out}, 11'h000);
		send(8'h30, 1'b1);
		supply_a_good_in = 1'b0;
		adc_base = 8'h60;
		repeat (5) @(negedge clk_in);
		chk("por_drop", {10'h000, por_release_out}, 11'h000);
		chk("code_drop", {3'h0, setpoint_code_out}, 11'h000);
		protect_fault_in = 1'b0;
		supply_a_good_in = 1'b1;
		wait_ready();
		chk("rescan_b", {3'h0, setting_b_out}, 11'h061);
		chk("rescan_c", {3'h0, setting_c_out}, 11'h062);
		give_verdict();
	end
endmodule
